// *** hw/fsp_guard_decode.v ***
// Decides whether one array address lies in the guarded region.
// Assumes a 32 MB array and the five guard bits plus complement.
`timescale 1ns/1ps
`include "fsp_regs.vh"

module fsp_guard_decode #(
    parameter AW = 25
) (
    input  wire [AW-1:0] addr_i,
    input  wire [4:0]    guard_i,
    input  wire          cmp_i,
    output reg           hit_o
);

    reg [AW:0] size;
    reg [AW:0] top;
    reg [2:0]  code;
    reg [2:0]  k;
    reg        in_rgn;

    // ----------------------------------------------------------------
    // Region size and side
    // ----------------------------------------------------------------
    always @*
    begin
        code   = guard_i[2:0];
        top    = {1'b1, {AW{1'b0}}};
        k      = (code > `FSP_GUARD_KMAX) ? `FSP_GUARD_KMAX : code;
        size   = {(AW+1){1'b0}};
        in_rgn = 1'b0;
        if (code == `FSP_GUARD_NONE)
        begin
            in_rgn = 1'b0;  // see R17
        end
        else if (code == `FSP_GUARD_ALL)
        begin
            in_rgn = 1'b1;  // see R17
        end
        else
        begin
            if (guard_i[4])
                size = {{AW{1'b0}}, 1'b1} << (`FSP_BLK_SHIFT + k);  // see R17
            else
                size = {{AW{1'b0}}, 1'b1} << (`FSP_FRAC_SHIFT + code);  // see R17
            if (guard_i[3])
                in_rgn = ({1'b0, addr_i} < size);
            else
                in_rgn = ({1'b0, addr_i} >= (top - size));
        end
        hit_o = in_rgn ^ cmp_i;  // see R06
    end

endmodule // fsp_guard_decode

// *** hw/fsp_status_regs.v ***
// Status and control word of the serial flash with its write protection.
// Assumes a command framer on ref_clk_i that gives one decoded pulse per
// command; rst_i stands for a power cycle.
`timescale 1ns/1ps
`include "fsp_regs.vh"

// Functional notes
// R01: Busy bit high while program, wipe or write
// R02: Latch flag low refuses writes, programs, wipes
// R03: Guard bits written only outside hardware lock
// R04: Refuse program and wipes inside guarded region
// R05: Chip wipe only if guard/complement uniform
// R06: Complement inverts the guarded region
// R07: Mode 00 writes allowed whenever latch set
// R08: Mode 01 locks while protect pin low
// R09: Mode 10 locks until power cycle
// R10: Mode 11 locks the status word forever; the code resets the mode to 00, so it ends at a power cycle
// R11: Quad enable turns pins into data lanes
// R12: Security lock bits set once, one each
// R13: Complement bit stored, default zero
// R14: Suspend sets erase or program pause flag
// R15: Resume and power cycle clear pause flags
// R16: Four-byte flag set, cleared, reset zero
// R17: Guard codes choose fractions or small blocks
// R18: Latch set by enable, cleared by ops
// R19: Read-only positions ignore written data
module fsp_status_regs #(
    parameter AW        = 25,
    parameter CW        = 24,
    parameter STATUS_WRITE_CMD_CYC  = 24'd1000,
    parameter PROG_CYC  = 24'd2000,
    parameter SE_CYC    = 24'd8000,
    parameter BE_CYC    = 24'd16000,
    parameter CE_CYC    = 24'd64000,
    parameter SEC_CYC   = 24'd2000
) (
    input  wire          ref_clk_i,
    input  wire          rst_i,
    input  wire          cmd_wren_i,
    input  wire          cmd_wrdi_i,
    input  wire          cmd_status_write_cmd_i,
    input  wire [15:0]   status_write_cmd_data_i,
    input  wire          cmd_prog_i,
    input  wire          cmd_sector_i,
    input  wire          cmd_block32_i,
    input  wire          cmd_block64_i,
    input  wire          cmd_chip_i,
    input  wire [AW-1:0] op_addr_i,
    input  wire          cmd_sec_prog_i,
    input  wire          cmd_sec_erase_i,
    input  wire          sec_sel_i,
    input  wire          cmd_suspend_i,
    input  wire          cmd_resume_i,
    input  wire          cmd_four_byte_addr_flag_i,
    input  wire          cmd_dis4b_i,
    input  wire          write_protect_pin_i,
    output wire [15:0]   status_o,
    output reg           cmd_done_o,
    output reg           cmd_refused_o,
    output wire          quad_io_enable_o,
    output wire [1:0]    security_ro_o,
    output wire          four_byte_addr_o
);

    localparam OP_NONE = 2'h0;
    localparam OP_STATUS_WRITE_CMD = 2'h1;
    localparam OP_PROG = 2'h2;
    localparam OP_WIPE = 2'h3;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg          wp_meta_q;
    reg          wp_sync_q;
    reg          wel_q;
    reg          wel_d;
    reg [4:0]    guard_q;
    reg [4:0]    guard_d;
    reg [1:0]    lock_q;
    reg [1:0]    lock_d;
    reg          qe_q;
    reg          qe_d;
    reg [1:0]    sec_q;
    reg [1:0]    sec_d;
    reg          cmp_q;
    reg          cmp_d;
    reg          epause_q;
    reg          epause_d;
    reg          ppause_q;
    reg          ppause_d;
    reg          addr4_q;
    reg          addr4_d;
    reg [1:0]    op_q;
    reg [1:0]    op_d;
    reg          run_q;
    reg          run_d;
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] cnt_d;
    reg          done_d;
    reg          refused_d;

    wire [AW-1:0] span_end;
    wire          hit_lo;
    wire          hit_hi;
    wire          wp_low;
    wire          sr_locked;
    wire          any_wipe;
    wire          busy;
    wire [1:0]    sec_new;
    reg  [AW-1:0] span_mask;

    // ----------------------------------------------------------------
    // Protect pin synchroniser
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_meta_q <= 1'b1;
            wp_sync_q <= 1'b1;
        end
        else
        begin
            wp_meta_q <= write_protect_pin_i;
            wp_sync_q <= wp_meta_q;
        end
    end

    // Pin is a data lane when quad enable is set
    assign wp_low = ~qe_q & ~wp_sync_q;  // see R11

    assign sr_locked = lock_q[1] |  // see R09 see R10
                       ((lock_q == `FSP_LOCK_HW) & wp_low);  // see R08 see R07

    // ----------------------------------------------------------------
    // Target span guard check
    // ----------------------------------------------------------------
    always @*
    begin
        span_mask = `FSP_SPAN_PAGE;
        if (cmd_sector_i)
            span_mask = `FSP_SPAN_4K;
        else if (cmd_block32_i)
            span_mask = `FSP_SPAN_32K;
        else if (cmd_block64_i)
            span_mask = `FSP_SPAN_64K;
    end

    assign span_end = op_addr_i | span_mask;
    assign any_wipe = cmd_sector_i | cmd_block32_i | cmd_block64_i;
    assign busy     = run_q;

    fsp_guard_decode #(
        .AW (AW)
    ) u_guard_lo (
        .addr_i  (op_addr_i & ~span_mask),
        .guard_i (guard_q),
        .cmp_i   (cmp_q),
        .hit_o   (hit_lo)
    );

    fsp_guard_decode #(
        .AW (AW)
    ) u_guard_hi (
        .addr_i  (span_end),
        .guard_i (guard_q),
        .cmp_i   (cmp_q),
        .hit_o   (hit_hi)
    );

    // Newly set lock bits of a status write
    assign sec_new = status_write_cmd_data_i[`FSP_BIT_SEC_HI:`FSP_BIT_SEC_LO] & ~sec_q;

    // ----------------------------------------------------------------
    // Command handling
    // ----------------------------------------------------------------
    always @*
    begin
        wel_d     = wel_q;
        guard_d   = guard_q;
        lock_d    = lock_q;
        qe_d      = qe_q;
        sec_d     = sec_q;
        cmp_d     = cmp_q;
        epause_d  = epause_q;
        ppause_d  = ppause_q;
        addr4_d   = addr4_q;
        op_d      = op_q;
        run_d     = run_q;
        cnt_d     = cnt_q;
        done_d    = 1'b0;
        refused_d = 1'b0;

        // Busy countdown
        if (run_q)
        begin
            if (cnt_q == {CW{1'b0}})
            begin
                run_d = 1'b0;  // see R01
                op_d  = OP_NONE;
            end
            else
            begin
                cnt_d = cnt_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end

        if (cmd_suspend_i)
        begin
            if (run_q && (op_q == OP_WIPE))
            begin
                epause_d = 1'b1;  // see R14
                run_d    = 1'b0;
                done_d   = 1'b1;
            end
            else if (run_q && (op_q == OP_PROG))
            begin
                ppause_d = 1'b1;  // see R14
                run_d    = 1'b0;
                done_d   = 1'b1;
            end
            else
            begin
                refused_d = 1'b1;
            end
        end
        else if (cmd_resume_i)
        begin
            if (epause_q | ppause_q)
            begin
                epause_d = 1'b0;  // see R15
                ppause_d = 1'b0;  // see R15
                run_d    = 1'b1;  // see R01
                done_d   = 1'b1;
            end
            else
            begin
                refused_d = 1'b1;
            end
        end
        else if (busy)
        begin
            // Only suspend and resume are decoded while an operation runs
            refused_d = cmd_wren_i | cmd_wrdi_i | cmd_status_write_cmd_i | cmd_prog_i |
                        any_wipe | cmd_chip_i | cmd_sec_prog_i | cmd_sec_erase_i |
                        cmd_four_byte_addr_flag_i | cmd_dis4b_i;
        end
        else if (cmd_wren_i)
        begin
            wel_d  = 1'b1;  // see R18
            done_d = 1'b1;
        end
        else if (cmd_wrdi_i)
        begin
            wel_d  = 1'b0;  // see R18
            done_d = 1'b1;
        end
        else if (cmd_four_byte_addr_flag_i)
        begin
            addr4_d = 1'b1;  // see R16
            done_d  = 1'b1;
        end
        else if (cmd_dis4b_i)
        begin
            addr4_d = 1'b0;  // see R16
            done_d  = 1'b1;
        end
        else if (cmd_status_write_cmd_i)
        begin
            if (!wel_q || sr_locked)  // see R02 see R03
            begin
                refused_d = 1'b1;
            end
            else
            begin
                // Busy, latch, pause and address flags are not taken
                guard_d = status_write_cmd_data_i[`FSP_BIT_BG_HI:`FSP_BIT_BG_LO];  // see R03 see R19
                lock_d  = status_write_cmd_data_i[`FSP_BIT_LOCK_HI:`FSP_BIT_LOCK_LO];
                qe_d    = status_write_cmd_data_i[`FSP_BIT_QE];  // see R11
                cmp_d   = status_write_cmd_data_i[`FSP_BIT_CMP];  // see R13
                if (sec_new != 2'h3)
                    sec_d = sec_q | sec_new;  // see R12
                wel_d   = 1'b0;  // see R18
                op_d    = OP_STATUS_WRITE_CMD;
                run_d   = 1'b1;  // see R01
                cnt_d   = STATUS_WRITE_CMD_CYC;
                done_d  = 1'b1;
            end
        end
        else if (cmd_prog_i || any_wipe || cmd_chip_i)
        begin
            if (!wel_q || epause_q || ppause_q)  // see R02
            begin
                refused_d = 1'b1;
            end
            else if (!cmd_chip_i && (hit_lo || hit_hi))  // see R04
            begin
                refused_d = 1'b1;
            end
            else if (cmd_chip_i &&
                     ({guard_q[2:0], cmp_q} != 4'h0) &&
                     ({guard_q[2:0], cmp_q} != 4'hf))  // see R05
            begin
                refused_d = 1'b1;
            end
            else
            begin
                wel_d  = 1'b0;  // see R18
                run_d  = 1'b1;  // see R01
                done_d = 1'b1;
                if (cmd_prog_i)
                begin
                    op_d  = OP_PROG;
                    cnt_d = PROG_CYC;
                end
                else if (cmd_chip_i)
                begin
                    op_d  = OP_WIPE;
                    cnt_d = CE_CYC;
                end
                else if (cmd_sector_i)
                begin
                    op_d  = OP_WIPE;
                    cnt_d = SE_CYC;
                end
                else
                begin
                    op_d  = OP_WIPE;
                    cnt_d = BE_CYC;
                end
            end
        end
        else if (cmd_sec_prog_i || cmd_sec_erase_i)
        begin
            if (!wel_q || sec_q[sec_sel_i])  // see R02 see R12
            begin
                refused_d = 1'b1;
            end
            else
            begin
                wel_d  = 1'b0;  // see R18
                op_d   = OP_PROG;
                run_d  = 1'b1;  // see R01
                cnt_d  = SEC_CYC;
                done_d = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wel_q         <= 1'b0;  // see R18
            guard_q       <= `FSP_GUARD_RST;
            lock_q        <= `FSP_LOCK_RST;  // see R09
            qe_q          <= 1'b0;  // see R11
            sec_q         <= `FSP_SEC_RST;
            cmp_q         <= 1'b0;  // see R13
            epause_q      <= 1'b0;  // see R15
            ppause_q      <= 1'b0;  // see R15
            addr4_q       <= 1'b0;  // see R16
            op_q          <= OP_NONE;
            run_q         <= 1'b0;
            cnt_q         <= {CW{1'b0}};
            cmd_done_o    <= 1'b0;
            cmd_refused_o <= 1'b0;
        end
        else
        begin
            wel_q         <= wel_d;
            guard_q       <= guard_d;
            lock_q        <= lock_d;
            qe_q          <= qe_d;
            sec_q         <= sec_d;
            cmp_q         <= cmp_d;
            epause_q      <= epause_d;
            ppause_q      <= ppause_d;
            addr4_q       <= addr4_d;
            op_q          <= op_d;
            run_q         <= run_d;
            cnt_q         <= cnt_d;
            cmd_done_o    <= done_d;
            cmd_refused_o <= refused_d;
        end
    end

    // ----------------------------------------------------------------
    // Status word
    // ----------------------------------------------------------------
    assign status_o = {epause_q, cmp_q, sec_q, addr4_q, ppause_q, qe_q,
                       lock_q, guard_q, wel_q, run_q};  // see R01 see R14

    assign quad_io_enable_o = qe_q;  // see R11
    assign security_ro_o    = sec_q;  // see R12
    assign four_byte_addr_o = addr4_q;

endmodule // fsp_status_regs

// *** inc/fsp_regs.vh ***
// Bit layout, lock modes and constants of the flash status word.
// Included by the status block and its guard decoder; definitions only.
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define FSP_BIT_WIP      0
`define FSP_BIT_WEL      1
`define FSP_BIT_BG_LO    2
`define FSP_BIT_BG_HI    6
`define FSP_BIT_LOCK_LO  7
`define FSP_BIT_LOCK_HI  8
`define FSP_BIT_QE       9
`define FSP_BIT_PPAUSE   10
`define FSP_BIT_ADDR4    11
`define FSP_BIT_SEC_LO   12
`define FSP_BIT_SEC_HI   13
`define FSP_BIT_CMP      14
`define FSP_BIT_EPAUSE   15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSP_GUARD_RST    5'h00
`define FSP_LOCK_RST     2'h0
`define FSP_SEC_RST      2'h0

// ----------------------------------------------------------------
// Status lock modes
// ----------------------------------------------------------------
`define FSP_LOCK_SW      2'h0
`define FSP_LOCK_HW      2'h1
`define FSP_LOCK_PWR     2'h2
`define FSP_LOCK_OTP     2'h3

// ----------------------------------------------------------------
// Guard decode
// ----------------------------------------------------------------
`define FSP_GUARD_NONE   3'h0
`define FSP_GUARD_ALL    3'h7
`define FSP_GUARD_KMAX   3'h4
`define FSP_FRAC_SHIFT   18
`define FSP_BLK_SHIFT    11

// ----------------------------------------------------------------
// Span masks of program and wipe targets
// ----------------------------------------------------------------
`define FSP_SPAN_PAGE    25'h00000ff
`define FSP_SPAN_4K      25'h0000fff
`define FSP_SPAN_32K     25'h0007fff
`define FSP_SPAN_64K     25'h000ffff

`endif

// *** sim/fsp_host_model.sv ***
// Host model that issues decoded command pulses to the status block.
// Assumes the block's answer is valid half a cycle after the edge that takes a pulse.
`timescale 1ns/1ps

module fsp_host_model (
    input  wire        ref_clk_i,
    input  wire        done_i,
    input  wire        refused_i,
    output reg  [13:0] cmd_o,
    output reg  [15:0] data_o,
    output reg  [24:0] addr_o,
    output reg         sel_o
);
    initial
    begin
        cmd_o  = 14'h0000;
        data_o = 16'h0000;
        addr_o = 25'h0000000;
        sel_o  = 1'b0;
    end

    // ----------------------------------------------------------------
    // One pulse per command, data inverted once released
    // ----------------------------------------------------------------
    task send(input [3:0] code, input [15:0] d, input [24:0] a, output [1:0] res);
        begin
            @(negedge ref_clk_i);
            data_o = d;
            addr_o = a;
            sel_o  = a[0];
            cmd_o  = 14'h0001 << code;
            @(negedge ref_clk_i);
            res    = {done_i, refused_i};
            cmd_o  = 14'h0000;
            data_o = ~d;
            addr_o = ~a;
            sel_o  = ~a[0];
        end
    endtask
endmodule // fsp_host_model

// *** sim/fsp_status_regs_asserts.sv ***
// Port-level checks of the status block.
// Assumes a bind to fsp_status_regs, one clock and an active-high reset.
`timescale 1ns/1ps

module fsp_status_regs_chk (
    input wire        ref_clk_i,
    input wire        rst_i,
    input wire        cmd_wren_i,
    input wire        cmd_status_write_cmd_i,
    input wire        cmd_prog_i,
    input wire        cmd_chip_i,
    input wire        cmd_suspend_i,
    input wire        cmd_resume_i,
    input wire        cmd_four_byte_addr_flag_i,
    input wire        write_protect_pin_i,
    input wire [15:0] status_o,
    input wire        cmd_done_o,
    input wire        cmd_refused_o,
    input wire        four_byte_addr_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    AST_LATCH_REFUSE: assert property (cmd_status_write_cmd_i && !status_o[1] |=> cmd_refused_o)
        else $error("status write without latch not refused");
    AST_LATCH_SET: assert property (cmd_wren_i && !status_o[0] |=> cmd_done_o && status_o[1])
        else $error("latch not set by enable");
    AST_WRITE_BUSY: assert property (cmd_status_write_cmd_i ##1 cmd_done_o |-> status_o[0] && !status_o[1])
        else $error("status write did not start busy");
    AST_BUSY_REFUSE: assert property (status_o[0] && (cmd_wren_i || cmd_prog_i) |=> cmd_refused_o)
        else $error("command accepted while busy");
    AST_PIN_LOCK: assert property (cmd_status_write_cmd_i && status_o[8:7] == 2'h1 && !status_o[9]
        && !(write_protect_pin_i || $past(write_protect_pin_i) || $past(write_protect_pin_i, 2)
        || $past(write_protect_pin_i, 3)) |=> cmd_refused_o)
        else $error("status write accepted with pin low");
    AST_MODE_LOCK: assert property (cmd_status_write_cmd_i && status_o[8] |=> cmd_refused_o)
        else $error("status write accepted in locked mode");
    AST_RO_KEEP: assert property (cmd_status_write_cmd_i ##1 cmd_done_o |->
        {status_o[15], status_o[11:10]} == $past({status_o[15], status_o[11:10]}))
        else $error("read-only flags changed by status write");
    AST_CHIP_MIX: assert property (cmd_chip_i && !status_o[0]
        && {status_o[4:2], status_o[14]} != 4'h0 && {status_o[4:2], status_o[14]} != 4'hf
        |=> cmd_refused_o)
        else $error("chip wipe accepted with mixed guard");
    AST_PAUSE: assert property (cmd_suspend_i ##1 cmd_done_o |->
        !status_o[0] && (status_o[15] || status_o[10]))
        else $error("suspend did not raise a pause flag");
    AST_RESUME: assert property (cmd_resume_i ##1 cmd_done_o |->
        status_o[0] && !status_o[15] && !status_o[10])
        else $error("resume did not clear pause flags");
    AST_ADDR4: assert property (cmd_four_byte_addr_flag_i && !status_o[0] |=> four_byte_addr_o && status_o[11])
        else $error("four-byte flag not set");
    AST_SEC_ONCE: assert property (status_o[13:12] != 2'h0 |=>
        (status_o[13:12] & $past(status_o[13:12])) == $past(status_o[13:12]))
        else $error("security lock bit cleared");
endmodule // fsp_status_regs_chk

bind fsp_status_regs fsp_status_regs_chk u_fsp_status_regs_chk (
    .ref_clk_i, .rst_i, .cmd_wren_i, .cmd_status_write_cmd_i, .cmd_prog_i, .cmd_chip_i, .cmd_suspend_i,
    .cmd_resume_i, .cmd_four_byte_addr_flag_i, .write_protect_pin_i, .status_o, .cmd_done_o,
    .cmd_refused_o, .four_byte_addr_o
);

// *** sim/fsp_status_regs_tb_top.sv ***
// Self-checking bench of the status block through its command pulses.
// Assumes the host model drives all commands; pin and reset come from here.
`timescale 1ns/1ps

module fsp_status_regs_tb_top;
    localparam [3:0] C_LATCH_ON = 4'h0, C_LATCH_OFF = 4'h1, C_SWRITE = 4'h2, C_PROG = 4'h3;
    localparam [3:0] C_W4K = 4'h4, C_W32K = 4'h5, C_W64K = 4'h6, C_CHIP = 4'h7;
    localparam [3:0] C_SPROG = 4'h8, C_SWIPE = 4'h9, C_PAUSE = 4'ha, C_RESUME = 4'hb;
    localparam [3:0] C_A4ON = 4'hc, C_A4OFF = 4'hd;
    localparam [1:0] DONE = 2'b10, REF = 2'b01;

    reg         ref_clk = 1'b0;
    reg         rst     = 1'b1;
    reg         wp_pin  = 1'b1;
    wire [13:0] cmd;
    wire [15:0] wdata;
    wire [24:0] addr;
    wire        sel;
    wire [15:0] status;
    wire        done;
    wire        refused;
    wire        quad;
    wire        addr4;
    wire [1:0]  sec_ro;
    integer     n_errors = 0;
    integer     checked  = 0;
    integer     i;
    reg [1:0]   res;
    reg [35:0]  tab [0:11];

    always #5 ref_clk = ~ref_clk;

    fsp_status_regs #(.STATUS_WRITE_CMD_CYC(24'd4), .PROG_CYC(24'd4), .SE_CYC(24'd4), .BE_CYC(24'd4),
        .CE_CYC(24'd4)) u_fsp_status_regs (
        .ref_clk_i(ref_clk), .rst_i(rst), .cmd_wren_i(cmd[0]), .cmd_wrdi_i(cmd[1]),
        .cmd_status_write_cmd_i(cmd[2]), .status_write_cmd_data_i(wdata), .cmd_prog_i(cmd[3]), .cmd_sector_i(cmd[4]),
        .cmd_block32_i(cmd[5]), .cmd_block64_i(cmd[6]), .cmd_chip_i(cmd[7]),
        .op_addr_i(addr), .cmd_sec_prog_i(cmd[8]), .cmd_sec_erase_i(cmd[9]), .sec_sel_i(sel),
        .cmd_suspend_i(cmd[10]), .cmd_resume_i(cmd[11]), .cmd_four_byte_addr_flag_i(cmd[12]),
        .cmd_dis4b_i(cmd[13]), .write_protect_pin_i(wp_pin), .status_o(status),
        .cmd_done_o(done), .cmd_refused_o(refused), .quad_io_enable_o(quad),
        .security_ro_o(sec_ro), .four_byte_addr_o(addr4));

    fsp_host_model u_fsp_host_model (.ref_clk_i(ref_clk), .done_i(done), .refused_i(refused),
        .cmd_o(cmd), .data_o(wdata), .addr_o(addr), .sel_o(sel));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task report_and_stop;
        begin
            if (n_errors == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    task check(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task op(input [3:0] c, input [15:0] d, input [24:0] a, input [1:0] exp);
        begin
            u_fsp_host_model.send(c, d, a, res);
            check(res, exp);
        end
    endtask

    task idle;
        integer k;
        begin
            k = 0;
            while (status[0] !== 1'b0 && k < 2100)
            begin
                @(negedge ref_clk);
                k = k + 1;
            end
            check(status[0], 1'b0);
        end
    endtask

    task swrite(input [15:0] d);
        begin
            op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
            op(C_SWRITE, d, 25'h0, DONE);
            idle;
        end
    endtask

    task power_cycle;
        begin
            @(negedge ref_clk);
            rst = 1'b1;
            repeat (2) @(negedge ref_clk);
            rst = 1'b0;
        end
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial
    begin
        tab[0]  = {C_PROG, 1'b0, 1'b0, 5'h01, 25'h1f80000};
        tab[1]  = {C_PROG, 1'b1, 1'b0, 5'h01, 25'h1f7ff00};
        tab[2]  = {C_PROG, 1'b0, 1'b1, 5'h01, 25'h1f7ff00};
        tab[3]  = {C_PROG, 1'b1, 1'b1, 5'h01, 25'h1f80000};
        tab[4]  = {C_W4K, 1'b0, 1'b0, 5'h11, 25'h1fff000};
        tab[5]  = {C_W4K, 1'b1, 1'b1, 5'h11, 25'h1fff000};
        tab[6]  = {C_W64K, 1'b0, 1'b1, 5'h19, 25'h0010000};
        tab[7]  = {C_W4K, 1'b1, 1'b1, 5'h19, 25'h0000000};
        tab[8]  = {C_W64K, 1'b0, 1'b0, 5'h07, 25'h0000000};
        tab[9]  = {C_W32K, 1'b1, 1'b1, 5'h07, 25'h1ff8000};
        tab[10] = {C_W32K, 1'b0, 1'b1, 5'h00, 25'h1ff8000};
        tab[11] = {C_PROG, 1'b1, 1'b0, 5'h00, 25'h0000000};
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        check(status, 16'h0000);
        check({quad, sec_ro, addr4}, 4'h0);
        op(C_SWRITE, 16'h0004, 25'h0, REF);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        check(status, 16'h0002);
        op(C_LATCH_OFF, 16'h0000, 25'h0, DONE);
        op(C_PROG, 16'h0000, 25'h0, REF);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_SWRITE, 16'hce07, 25'h0, DONE);
        check(status[1:0], 2'b01);
        op(C_LATCH_ON, 16'h0000, 25'h0, REF);
        idle;
        check({status, quad}, {16'h4204, 1'b1});
        for (i = 0; i < 12; i = i + 1)
        begin
            swrite({1'b0, tab[i][30], 7'h00, tab[i][29:25], 2'b00});
            op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
            op(tab[i][35:32], 16'h0000, tab[i][24:0], tab[i][31] ? DONE : REF);
            idle;
        end
        swrite(16'h4004);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_CHIP, 16'h0000, 25'h0, REF);
        swrite(16'h401c);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_CHIP, 16'h0000, 25'h0, DONE);
        idle;
        swrite(16'h0000);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_W4K, 16'h0000, 25'h0, DONE);
        op(C_PAUSE, 16'h0000, 25'h0, DONE);
        check({status[15], status[0]}, 2'b10);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_PROG, 16'h0000, 25'h0, REF);
        op(C_RESUME, 16'h0000, 25'h0, DONE);
        check({status[15], status[0]}, 2'b01);
        idle;
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_PROG, 16'h0000, 25'h100, DONE);
        op(C_PAUSE, 16'h0000, 25'h0, DONE);
        check({status[10], status[0]}, 2'b10);
        op(C_A4ON, 16'h0000, 25'h0, DONE);
        op(C_A4OFF, 16'h0000, 25'h0, DONE);
        check(addr4, 1'b0);
        op(C_A4ON, 16'h0000, 25'h0, DONE);
        check({addr4, status[11]}, 2'b11);
        swrite(16'h0100);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_SWRITE, 16'h0000, 25'h0, REF);
        power_cycle;
        check(status, 16'h0000);
        swrite(16'h0080);
        wp_pin = 1'b0;
        repeat (3) @(negedge ref_clk);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_SWRITE, 16'h0084, 25'h0, REF);
        wp_pin = 1'b1;
        repeat (3) @(negedge ref_clk);
        op(C_SWRITE, 16'h0084, 25'h0, DONE);
        idle;
        check(status, 16'h0084);
        swrite(16'h1080);
        check(sec_ro, 2'b01);
        swrite(16'h0080);
        check(status, 16'h1080);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_SPROG, 16'h0000, 25'h0, REF);
        op(C_SWIPE, 16'h0000, 25'h1, DONE);
        idle;
        swrite(16'h1180);
        op(C_LATCH_ON, 16'h0000, 25'h0, DONE);
        op(C_SWRITE, 16'h0000, 25'h0, REF);
        check(status, 16'h1182);
        report_and_stop;
    end

    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
endmodule // fsp_status_regs_tb_top
